// File: hdl/iat_regs.sv
// Strobed register access was decided locally.
`timescale 1ns/10ps
module iat_regs
  import iat_pkg::*;
#(
  parameter int RESULT_WIDTH = 18
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Conversion results.
  input  wire logic        sample_valid,
  input  wire logic [17:0] sample,
  // Alarm outputs.
  output logic             input_tripped_flag_a,
  output logic             input_tripped_flag_b,
  output logic             overall_tripped_alarm_summary,
  output logic             irq
);

  // ***************************************************************
  // Parameter check
  // ***************************************************************
  if (RESULT_WIDTH != 18) begin : g_bad_width
    $error("Only 18-bit results are supported.");
  end

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [7:0]  input_alarm_hysteresis;
    logic [15:0] input_alarm_upper_limit;
    logic [15:0] input_alarm_lower_limit;
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] rdata;
    logic        flag_a;
    logic        flag_b;
    logic        summary;
    logic        irq;
  } iat_regs_s;

  iat_regs_s state_reg;
  iat_regs_s state_next;
  iat_sel_e  sel;
  logic [31:0] upper_word;
  logic [31:0] lower_word;
  logic [31:0] events;

  iat_cmp_if cmp_bus ();

  // Register decode on the word base address.
  function automatic iat_sel_e iat_decode(input logic [7:0] a);
    case (a & IAT_BASE_MASK)
      IAT_UPPER_BASE: iat_decode = IAT_SEL_UPPER;
      IAT_LOWER_BASE: iat_decode = IAT_SEL_LOWER;
      default:        iat_decode = IAT_SEL_NONE;
    endcase
  endfunction : iat_decode

  assign sel = iat_decode(addr);

  // Read images with reserved fields as zero.
  always_comb begin
    upper_word = {state_reg.input_alarm_hysteresis, 8'h00,
                  state_reg.input_alarm_upper_limit};
    lower_word = {16'h0000, state_reg.input_alarm_lower_limit};
  end

  // Widened limits feed the comparator.
  always_comb begin
    cmp_bus.upper_limit  = {state_reg.input_alarm_upper_limit, IAT_APPEND};
    cmp_bus.lower_limit  = {state_reg.input_alarm_lower_limit, IAT_APPEND};
    cmp_bus.hyst         = state_reg.input_alarm_hysteresis[7:2];
    cmp_bus.sample_valid = sample_valid;
    cmp_bus.sample       = sample;
  end

  iat_compare u_cmp (
    .clk (clk),
    .rst (rst),
    .cmp (cmp_bus)
  );

  // Sticky events: tripped and active bits from the comparator.
  always_comb begin
    events = '0;
    events[IAT_TRIP_HIGH] = cmp_bus.above;
    events[IAT_TRIP_LOW]  = cmp_bus.below;
    events[IAT_ACT_HIGH]  = cmp_bus.above;
    events[IAT_ACT_LOW]   = cmp_bus.below;
    events[IAT_SUMMARY]   = cmp_bus.above | cmp_bus.below;
  end

  // Next-state logic for the bank.
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;
    if (wr) begin
      if (sel == IAT_SEL_UPPER) begin
        state_next.input_alarm_hysteresis  = wdata[31:IAT_HYST_LSB];
        state_next.input_alarm_upper_limit = wdata[15:0];
      end else if (sel == IAT_SEL_LOWER) begin
        state_next.input_alarm_lower_limit = wdata[15:0];
      end else if ((addr & IAT_BASE_MASK) == IAT_MASK_BASE) begin
        state_next.mask = wdata & IAT_STATUS_BITS;
      end
    end
    if (rd) begin
      if (sel == IAT_SEL_UPPER) begin
        state_next.rdata = upper_word;
      end else if (sel == IAT_SEL_LOWER) begin
        state_next.rdata = lower_word;
      end else if ((addr & IAT_BASE_MASK) == IAT_ALARM_BASE) begin
        state_next.rdata  = state_reg.status;
        state_next.status = 32'h0000_0000;
      end else if ((addr & IAT_BASE_MASK) == IAT_MASK_BASE) begin
        state_next.rdata = state_reg.mask;
      end
    end
    // A new event wins over the clear by read.
    state_next.status  = state_next.status | events;
    state_next.flag_a  = cmp_bus.above;
    state_next.flag_b  = cmp_bus.below;
    state_next.summary = cmp_bus.above | cmp_bus.below;
    state_next.irq     = |(state_next.status & state_next.mask);
  end

  // Registers the bank.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '{input_alarm_hysteresis:  IAT_HYST_RESET,
                     input_alarm_upper_limit: IAT_UPPER_RESET,
                     input_alarm_lower_limit: IAT_LOWER_RESET,
                     mask:                    IAT_MASK_RESET,
                     default:                 '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign rdata                         = state_reg.rdata;
  assign input_tripped_flag_a          = state_reg.flag_a;
  assign input_tripped_flag_b          = state_reg.flag_b;
  assign overall_tripped_alarm_summary = state_reg.summary;
  assign irq                           = state_reg.irq;

  chk_upper_reset: assert property (@(posedge clk)
    rst |=> state_reg.input_alarm_upper_limit == IAT_UPPER_RESET &&
            state_reg.input_alarm_hysteresis == IAT_HYST_RESET)
    else $error("Upper register reset value wrong.");
  chk_lower_reset: assert property (@(posedge clk)
    rst |=> state_reg.input_alarm_lower_limit == IAT_LOWER_RESET)
    else $error("Lower register reset value wrong.");
  chk_upper_read: assert property (@(posedge clk) disable iff (rst)
    rd && sel == IAT_SEL_UPPER |=> rdata[23:16] == 8'h00 &&
    rdata[15:0] == $past(state_reg.input_alarm_upper_limit))
    else $error("Upper read image wrong.");
  chk_lower_read: assert property (@(posedge clk) disable iff (rst)
    rd && sel == IAT_SEL_LOWER |=> rdata[31:16] == 16'h0000)
    else $error("Lower read reserved bits not zero.");
  chk_lower_write: assert property (@(posedge clk) disable iff (rst)
    wr && sel == IAT_SEL_LOWER |=> state_reg.input_alarm_lower_limit == $past(wdata[15:0]))
    else $error("Lower write failed.");
  chk_hyst_write: assert property (@(posedge clk) disable iff (rst)
    wr && sel == IAT_SEL_UPPER |=> state_reg.input_alarm_hysteresis == $past(wdata[31:24]))
    else $error("Hysteresis write failed.");
  chk_summary_or: assert property (@(posedge clk) disable iff (rst)
    ##1 overall_tripped_alarm_summary == (input_tripped_flag_a | input_tripped_flag_b))
    else $error("Summary is not the OR of flags.");
  chk_limit_widen: assert property (@(posedge clk) disable iff (rst)
    cmp_bus.upper_limit[1:0] == 2'h0 && cmp_bus.lower_limit[1:0] == 2'h0)
    else $error("Limits not widened with zeros.");
  chk_read_clears: assert property (@(posedge clk) disable iff (rst)
    rd && (addr & IAT_BASE_MASK) == IAT_ALARM_BASE |=> state_reg.status == $past(events))
    else $error("Status read did not clear.");
  chk_summary_sticky: assert property (@(posedge clk) disable iff (rst)
    overall_tripped_alarm_summary |-> state_reg.status[IAT_SUMMARY])
    else $error("Summary set without its status bit.");
  chk_high_sticky: assert property (@(posedge clk) disable iff (rst)
    input_tripped_flag_a |-> state_reg.status[IAT_TRIP_HIGH])
    else $error("Upper alarm set without its status bit.");

endmodule : iat_regs

// File: include/iat_pkg.sv
// Notes on behaviour
// - Upper-limit/hysteresis register occupies bytes 24h (LSB) through 27h (MSB).
// - Bits 31..24 hold hysteresis; host writes zeros in low two bits; resets 00h.
// - Upper comparison limit is bits 15..0 with 00b appended; resets FFFFh.
// - Bits 23..16 of upper-limit register are read-only and read 00h.
// - Lower-limit register occupies bytes 28h (LSB) through 2Bh (MSB).
// - Lower comparison limit is bits 15..0 with 00b appended; resets 0000h.
// - Upper sixteen bits of lower-limit register read 0000h.
// - Summary flag is the OR of all tripped alarm flags.
package iat_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0]  IAT_UPPER_BASE   = 8'h24;
  localparam logic [7:0]  IAT_LOWER_BASE   = 8'h28;
  localparam logic [7:0]  IAT_ALARM_BASE   = 8'h20;
  localparam logic [7:0]  IAT_MASK_BASE    = 8'h2C;
  localparam logic [7:0]  IAT_BASE_MASK    = 8'hFC;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int          IAT_HYST_LSB     = 24;
  localparam int          IAT_TRIP_HIGH    = 4;
  localparam int          IAT_TRIP_LOW     = 5;
  localparam int          IAT_ACT_HIGH     = 10;
  localparam int          IAT_ACT_LOW      = 11;
  localparam int          IAT_SUMMARY      = 0;
  localparam logic [7:0]  IAT_HYST_RESET   = 8'h00;
  localparam logic [15:0] IAT_UPPER_RESET  = 16'hFFFF;
  localparam logic [15:0] IAT_LOWER_RESET  = 16'h0000;
  localparam logic [1:0]  IAT_APPEND       = 2'h0;
  localparam logic [31:0] IAT_MASK_RESET   = 32'h0000_0000;
  localparam logic [31:0] IAT_STATUS_BITS  = 32'h0000_0C31;

  typedef enum logic [2:0] {
    IAT_SEL_NONE  = 3'b001,
    IAT_SEL_UPPER = 3'b010,
    IAT_SEL_LOWER = 3'b100
  } iat_sel_e;

endpackage : iat_pkg

// File: include/iat_cmp_if.sv
`timescale 1ns/10ps
// Limits and result between the register bank and the comparator.
interface iat_cmp_if;
  logic [17:0] upper_limit;
  logic [17:0] lower_limit;
  logic [5:0]  hyst;
  logic        sample_valid;
  logic [17:0] sample;
  logic        above;
  logic        below;
  modport bank (output upper_limit, lower_limit, hyst, sample_valid, sample,
                input above, below);
  modport cmp  (input upper_limit, lower_limit, hyst, sample_valid, sample,
                output above, below);
endinterface : iat_cmp_if

// File: hdl/iat_compare.sv
`timescale 1ns/10ps
module iat_compare
  import iat_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Limits and conversion result.
  iat_cmp_if.cmp   cmp
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic above;
    logic below;
  } iat_cmp_s;

  iat_cmp_s state_reg;
  iat_cmp_s state_next;
  logic [18:0] upper_release;
  logic [18:0] lower_release;

  // Release points move inside the window by the hysteresis amount.
  always_comb begin
    upper_release = {1'b0, cmp.upper_limit} - {13'h0000, cmp.hyst};
    lower_release = {1'b0, cmp.lower_limit} + {13'h0000, cmp.hyst};
  end

  // Each alarm sets past its limit and clears only once back past release.
  always_comb begin
    state_next = state_reg;
    if (cmp.sample_valid) begin
      if (cmp.sample > cmp.upper_limit) begin
        state_next.above = 1'b1;
      end else if (upper_release[18] || {1'b0, cmp.sample} < upper_release) begin
        state_next.above = 1'b0;
      end
      if (cmp.sample < cmp.lower_limit) begin
        state_next.below = 1'b1;
      end else if ({1'b0, cmp.sample} > lower_release) begin
        state_next.below = 1'b0;
      end
    end
  end

  // Registers the comparator state.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cmp.above = state_reg.above;
  assign cmp.below = state_reg.below;

  chk_above_sets: assert property (@(posedge clk) disable iff (rst)
    cmp.sample_valid && cmp.sample > cmp.upper_limit |=> cmp.above)
    else $error("Upper alarm did not set.");
  chk_below_sets: assert property (@(posedge clk) disable iff (rst)
    cmp.sample_valid && cmp.sample < cmp.lower_limit |=> cmp.below)
    else $error("Lower alarm did not set.");
  chk_idle_holds: assert property (@(posedge clk) disable iff (rst)
    !cmp.sample_valid |=> $stable(cmp.above) && $stable(cmp.below))
    else $error("Alarm changed without a sample.");

endmodule : iat_compare

// File: test/iat_host.sv
`timescale 1ns/10ps
// ****************************************
// Host controller on the register port.
// ****************************************
module iat_host (
  // Clock.
  input  wire logic        clk,
  // Register port.
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd
);
  // Expected read data and the bits of it that are compared.
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  // The bus is idle from time zero.
  initial begin
    addr  = 8'h00;
    wdata = 32'h0000_0000;
    wr    = 1'h0;
    rd    = 1'h0;
  end

  // One-cycle write; the two low hysteresis bits always go out as zero.
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (a[7:2] == 6'h09) v[25:24] = 2'h0;
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_word

  // One-cycle read; the expectation is queued for the output monitor.
  task automatic rd_word(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'h0;
  endtask : rd_word
endmodule : iat_host

// File: test/test_iat_regs.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
// ****************************************
// Self-checking bench of the alarm limit registers.
// ****************************************
module test_iat_regs;
  logic        clk, rst, wr, rd, sample_valid, flag_a, flag_b, summary, irq, rd_d;
  logic [7:0]  addr, hb;
  logic [31:0] wdata, rdata, e, m, seed_v;
  logic [17:0] sample, lim;
  logic [15:0] u, l;
  int          n_fail = 0;
  int          compares = 0;

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  iat_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  iat_regs dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sample_valid(sample_valid), .sample(sample), .input_tripped_flag_a(flag_a),
    .input_tripped_flag_b(flag_b), .overall_tripped_alarm_summary(summary), .irq(irq));

  // Read data stand in the cycle after the strobe; compare with the oldest note.
  always @(posedge clk) begin
    if (rd_d) begin
      e = host.exp_q.pop_front();
      m = host.msk_q.pop_front();
      `CHK(rdata & m, e)
    end
    rd_d <= rd;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // One conversion result, then the alarm outputs two cycles after it is taken.
  task automatic smp(input logic [17:0] v, input logic ea, eb, ei);
    @(posedge clk);
    sample       <= v;
    sample_valid <= 1'h1;
    @(posedge clk);
    sample_valid <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(flag_a, ea)
    `CHK(flag_b, eb)
    `CHK(summary, ea | eb)
    `CHK(irq, ei)
  endtask : smp

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    clk = 1'h0; rst = 1'h1; rd_d = 1'h0; sample_valid = 1'h0; sample = 18'h0;
    seed_v = $urandom(32'hA2B6);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      host.rd_word(8'h24 + 8'(i), 32'h0000_FFFF, '1);
      host.rd_word(8'h28 + 8'(i), 32'h0000_0000, '1);
    end
    host.rd_word(8'h2C, 32'h0000_0000, '1);
    host.rd_word(8'h20, 32'h0000_0000, '1);
    host.rd_word(8'h30, 32'h0000_0000, '1);
    $display("test reset values done");
    u  = 16'h8000 + 16'($urandom % 32'h7FF0);
    l  = 16'h0100 + 16'($urandom % 32'h7E00);
    hb = 8'($urandom) | 8'h03;
    host.wr_word(8'h27, {hb, 8'hFF, u});
    host.wr_word(8'h2A, {16'hFFFF, l});
    host.rd_word(8'h26, {hb & 8'hFC, 8'h00, u}, '1);
    host.rd_word(8'h29, {16'h0000, l}, '1);
    host.wr_word(8'h30, 32'hFFFF_FFFF);
    host.rd_word(8'h24, {hb & 8'hFC, 8'h00, u}, '1);
    $display("test write readback done");
    host.wr_word(8'h25, {8'h14, 8'h00, u});
    host.wr_word(8'h2C, 32'h0000_0010);
    host.rd_word(8'h2C, 32'h0000_0010, '1);
    lim = {u, 2'h0};
    smp(lim, 1'h0, 1'h0, 1'h0);
    smp(lim + 18'h1, 1'h1, 1'h0, 1'h1);
    smp(lim - 18'h5, 1'h1, 1'h0, 1'h1);
    smp(lim - 18'h6, 1'h0, 1'h0, 1'h1);
    host.rd_word(8'h20, 32'h0000_0411, '1);
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, 1'h0)
    host.rd_word(8'h20, 32'h0000_0000, '1);
    $display("test upper alarm done");
    lim = {l, 2'h0};
    smp(lim, 1'h0, 1'h0, 1'h0);
    smp(lim - 18'h1, 1'h0, 1'h1, 1'h0);
    smp(lim + 18'h5, 1'h0, 1'h1, 1'h0);
    smp(lim + 18'h6, 1'h0, 1'h0, 1'h0);
    host.rd_word(8'h20, 32'h0000_0821, '1);
    $display("test lower alarm done");
    summarize();
  end
endmodule : test_iat_regs
